/* core/iru_pkg.sv */
/*
  Package for the interrupt-return unit: opcodes, state-bit masks,
  register map of the Avalon-MM slave and reset values.
  Assumes big-endian bit numbering (bit 0 is the msb of a 64-bit word).
*/
`default_nettype none

package iru_pkg;

  localparam logic [5:0]  OPC_PRIMARY    = 6'h13;  // 19
  localparam logic [9:0]  XO_INT_RET     = 10'h032; // 50
  localparam logic [9:0]  XO_INT_RET_DW  = 10'h012; // 18
  localparam logic [9:0]  XO_SVC_RET     = 10'h052; // 82

  // mask of state bits 16-31 (lsb-index 47..32)
  localparam logic [63:0] MASK_WORD_RET  = 64'h0000_FFFF_0000_0000;
  // bits 0, 48-55, 57-59, 62-63
  localparam logic [63:0] MASK_DW_RET    = 64'h8000_0000_0000_FF73;
  // sixty-four-bit mode bit 0 -> lsb-index 63
  localparam int          POS_SF         = 63;
  // problem-state bit 49 -> lsb-index 14
  localparam int          POS_PROBLEM    = 14;
  // exception-enable bit 48 -> lsb-index 15
  localparam int          POS_EXC_EN     = 15;

  // register byte offsets
  localparam logic [5:0] OFF_CTRL     = 6'h00;
  localparam logic [5:0] OFF_STATUS   = 6'h04;
  localparam logic [5:0] OFF_MASK     = 6'h08;
  localparam logic [5:0] OFF_STATE_LO = 6'h0C;
  localparam logic [5:0] OFF_STATE_HI = 6'h10;
  localparam logic [5:0] OFF_COUNT    = 6'h14;

  // status bit positions
  localparam int ST_RETURN   = 0;
  localparam int ST_PRIV     = 1;
  localparam int ST_ILLEGAL  = 2;
  localparam int ST_REDELIV  = 3;
  localparam int ST_W        = 4;

  localparam logic [63:0] RST_STATE    = 64'h8000_0000_0000_0000;
  localparam logic [31:0] RST_CTRL     = 32'h0000_0001;
  localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

  typedef enum logic [1:0] {IRU_OP_NONE, IRU_OP_RET, IRU_OP_RET_DW,
                            IRU_OP_SVC} iru_op_e;

endpackage

`default_nettype wire

/* core/iru_addr_form.sv */
/*
  Forms the next fetch address from a saved address.
  Assumes purely combinational use by the unit's main module.
*/
`timescale 1ns/1ps
`default_nettype none

module iru_addr_form (
  input  wire logic [63:0] i_addr,
  input  wire logic        i_sf,
  output logic      [63:0] o_addr
);

  assign o_addr = i_sf ? {i_addr[63:2], 2'h0}
                       : {32'h0000_0000, i_addr[31:2], 2'h0};

endmodule

`default_nettype wire

/* core/iru_top.sv */
/*
  Interrupt-return unit: executes the word, doubleword and supervisor-
  call return instructions, restores machine state, redirects fetch.
  Assumes decode presents a one-cycle issue pulse with the instruction
  word, special registers as inputs, and Avalon-MM software access.
*/
// The address map and the Avalon-MM interface to the registers were left to the implementer.
// Summary of operation
// - xo 50: copy saved state 16-31
// - word return fetches at saved address
// - link flag: link register may be undefined
// - condition and exception registers untouched
// - all returns privileged, wait for drain
// - xo 18: copy bits 0,48-55,57-59,62-63
// - no pending enabled: fetch under new state
// - 64-bit mode: saved address, low bits zero
// - 32-bit mode: word address, high cleared
// - enabled pending: raise, save next address
// - 32-bit core rejects doubleword return
// - xo 82: copy count 16-31
// - supervisor return fetches at link register
// - link flag: link register may be undefined
`timescale 1ns/1ps
`default_nettype none

module iru_top #(
  parameter bit IS_64BIT = 1'b1
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_issue,
  input  wire logic [31:0] i_instr,
  input  wire logic        i_older_done,
  input  wire logic [63:0] i_save_restore_addr_reg,
  input  wire logic [63:0] i_save_restore_state_reg,
  input  wire logic [63:0] i_count_reg,
  input  wire logic [63:0] i_link_reg,
  input  wire logic        i_exc_pending,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_busy,
  output logic             o_redirect,
  output logic      [63:0] o_redirect_addr,
  output logic      [63:0] o_machine_state_reg,
  output logic             o_exc_raise,
  output logic             o_priv_exc,
  output logic             o_illegal_exc,
  output logic             o_save_addr_we,
  output logic      [63:0] o_save_addr_value,
  output logic             o_link_undefined,
  output logic             o_irq
);

  typedef enum logic [1:0] {IRU_IDLE, IRU_DRAIN, IRU_DONE} iru_state_e;

  ////////////////////////////////////////////////////////////////////////
  // decode

  wire       is_primary = i_instr[31:26] == iru_pkg::OPC_PRIMARY;
  wire [9:0] xo         = i_instr[10:1];
  wire       link_bit   = i_instr[0];
  wire       dec_ret    = is_primary && xo == iru_pkg::XO_INT_RET;
  wire       dec_ret_dw = is_primary && xo == iru_pkg::XO_INT_RET_DW;
  wire       dec_svc    = is_primary && xo == iru_pkg::XO_SVC_RET;
  wire       dec_any    = dec_ret || dec_ret_dw || dec_svc;
  wire       in_problem;
  wire       take       = i_issue && dec_any && !o_busy;
  wire       want_priv  = take && in_problem;
  wire       want_ill   = take && !in_problem && dec_ret_dw
                          && !IS_64BIT;
  wire       want_exec  = take && !want_priv && !want_ill;

  ////////////////////////////////////////////////////////////////////////
  // state

  iru_state_e            state_reg, state_next;
  iru_pkg::iru_op_e      op_reg;
  logic                  link_reg_q;
  logic [63:0]           msr_reg;
  logic [63:0]           new_msr;
  logic [63:0]           target_raw;
  logic [63:0]           target;
  logic                  ctrl_reg;
  logic [iru_pkg::ST_W-1:0] status_reg;
  logic [iru_pkg::ST_W-1:0] mask_reg;
  logic [31:0]           cnt_reg;

  assign in_problem = msr_reg[iru_pkg::POS_PROBLEM];

  // restored state per operation
  always_comb begin
    unique case (op_reg)
      iru_pkg::IRU_OP_RET:    new_msr = (msr_reg & ~iru_pkg::MASK_WORD_RET)
          | (i_save_restore_state_reg & iru_pkg::MASK_WORD_RET);
      iru_pkg::IRU_OP_RET_DW: new_msr = (msr_reg & ~iru_pkg::MASK_DW_RET)
          | (i_save_restore_state_reg & iru_pkg::MASK_DW_RET);
      iru_pkg::IRU_OP_SVC:    new_msr = (msr_reg & ~iru_pkg::MASK_WORD_RET)
          | (i_count_reg & iru_pkg::MASK_WORD_RET);
      iru_pkg::IRU_OP_NONE:   new_msr = msr_reg;
    endcase
  end

  assign target_raw = (op_reg == iru_pkg::IRU_OP_SVC) ? i_link_reg
                      : i_save_restore_addr_reg;

  iru_addr_form u_addr (
    .i_addr (target_raw),
    .i_sf   (new_msr[iru_pkg::POS_SF] || op_reg != iru_pkg::IRU_OP_RET_DW),
    .o_addr (target)
  );

  wire finish   = state_reg == IRU_DRAIN && i_older_done;
  wire redeliv  = finish && ctrl_reg && i_exc_pending
                  && new_msr[iru_pkg::POS_EXC_EN];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      IRU_IDLE:  if (want_exec) state_next = IRU_DRAIN;
      IRU_DRAIN: if (i_older_done) state_next = IRU_DONE;
      IRU_DONE:  state_next = IRU_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg  <= IRU_IDLE;
      op_reg     <= iru_pkg::IRU_OP_NONE;
      link_reg_q <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (want_exec && state_reg == IRU_IDLE) begin
        op_reg     <= dec_ret ? iru_pkg::IRU_OP_RET
                    : dec_ret_dw ? iru_pkg::IRU_OP_RET_DW
                    : iru_pkg::IRU_OP_SVC;
        link_reg_q <= link_bit;
      end
    end
  end

  // machine state and fetch redirect; cr0 and xer have no port here
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      msr_reg           <= iru_pkg::RST_STATE;
      o_redirect        <= 1'b0;
      o_redirect_addr   <= 64'h0;
      o_exc_raise       <= 1'b0;
      o_save_addr_we    <= 1'b0;
      o_save_addr_value <= 64'h0;
      o_link_undefined  <= 1'b0;
      o_priv_exc        <= 1'b0;
      o_illegal_exc     <= 1'b0;
    end else begin
      o_priv_exc    <= want_priv;
      o_illegal_exc <= want_ill;
      o_redirect     <= finish && !redeliv;
      o_exc_raise    <= redeliv;
      o_save_addr_we <= redeliv;
      o_link_undefined <= finish && link_reg_q;
      if (finish) begin
        msr_reg           <= new_msr;
        o_redirect_addr   <= target;
        o_save_addr_value <= target;
      end
    end
  end

  assign o_busy              = state_reg != IRU_IDLE;
  assign o_machine_state_reg = msr_reg;

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: zero wait on reads, one on nothing

  wire [iru_pkg::ST_W-1:0] events = {redeliv, want_ill, want_priv, finish};
  wire sel_ctrl  = i_avs_address == iru_pkg::OFF_CTRL;
  wire sel_stat  = i_avs_address == iru_pkg::OFF_STATUS;
  wire sel_mask  = i_avs_address == iru_pkg::OFF_MASK;
  wire sel_slo   = i_avs_address == iru_pkg::OFF_STATE_LO;
  wire sel_shi   = i_avs_address == iru_pkg::OFF_STATE_HI;
  wire sel_cnt   = i_avs_address == iru_pkg::OFF_COUNT;
  wire [iru_pkg::ST_W-1:0] w1c = (i_avs_write && sel_stat)
                                 ? i_avs_writedata[iru_pkg::ST_W-1:0]
                                 : '0;
  wire [31:0] rd_mux = sel_ctrl ? {31'h0, ctrl_reg}
                     : sel_stat ? {28'h0, status_reg}
                     : sel_mask ? {28'h0, mask_reg}
                     : sel_slo  ? msr_reg[31:0]
                     : sel_shi  ? msr_reg[63:32]
                     : sel_cnt  ? cnt_reg
                     : iru_pkg::UNMAPPED_RD;

  assign o_avs_waitrequest = 1'b0;
  assign o_irq             = |(status_reg & mask_reg);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_reg   <= iru_pkg::RST_CTRL[0];
      status_reg <= '0;
      mask_reg   <= '0;
      cnt_reg    <= 32'h0;
    end else begin
      status_reg <= (status_reg & ~w1c) | events;  // set wins over clear
      if (i_avs_write && sel_ctrl) ctrl_reg <= i_avs_writedata[0];
      if (i_avs_write && sel_mask)
        mask_reg <= i_avs_writedata[iru_pkg::ST_W-1:0];
      if (finish) cnt_reg <= cnt_reg + 32'h1;
    end
  end

  assign o_avs_readdata = i_avs_read ? rd_mux : 32'h0;

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_priv_block: assert property (
    @(posedge i_clk) disable iff (i_reset)
    want_priv
    |=> o_priv_exc && !o_busy)
    else $error("privileged return not suppressed");

  a_priv_keep: assert property (
    @(posedge i_clk) disable iff (i_reset)
    want_priv
    |=> $stable(o_machine_state_reg) && !o_redirect)
    else $error("privileged return changed state");

  a_ill_dw: assert property (
    @(posedge i_clk) disable iff (i_reset)
    want_ill
    |=> o_illegal_exc && state_reg == IRU_IDLE)
    else $error("doubleword return not rejected");

  a_drain_wait: assert property (
    @(posedge i_clk) disable iff (i_reset)
    state_reg == IRU_DRAIN && !i_older_done
    |=> !o_redirect)
    else $error("redirect before drain");

  a_sync_hold: assert property (
    @(posedge i_clk) disable iff (i_reset)
    state_reg == IRU_DRAIN && !i_older_done
    |=> $stable(o_machine_state_reg))
    else $error("state changed before drain");

  a_redirect_addr: assert property (
    @(posedge i_clk) disable iff (i_reset)
    o_redirect
    |-> o_redirect_addr[1:0] == 2'h0)
    else $error("redirect not word aligned");

  a_word_ret_msr: assert property (
    @(posedge i_clk) disable iff (i_reset)
    finish && op_reg == iru_pkg::IRU_OP_RET
    |=> o_machine_state_reg[47:32] == $past(i_save_restore_state_reg[47:32]))
    else $error("state bits not restored");

  a_word_target: assert property (
    @(posedge i_clk) disable iff (i_reset)
    finish && op_reg == iru_pkg::IRU_OP_RET && !redeliv
    |=> o_redirect && o_redirect_addr ==
        {$past(i_save_restore_addr_reg[63:2]), 2'h0})
    else $error("word return target wrong");

  a_next_state: assert property (
    @(posedge i_clk) disable iff (i_reset)
    finish && !redeliv
    |=> o_redirect && o_machine_state_reg == $past(new_msr))
    else $error("fetch not under restored state");

  a_svc_msr: assert property (
    @(posedge i_clk) disable iff (i_reset)
    finish && op_reg == iru_pkg::IRU_OP_SVC
    |=> o_machine_state_reg[47:32] == $past(i_count_reg[47:32]))
    else $error("count bits not restored");

  a_svc_target: assert property (
    @(posedge i_clk) disable iff (i_reset)
    finish && op_reg == iru_pkg::IRU_OP_SVC && !redeliv
    |=> o_redirect && o_redirect_addr == {$past(i_link_reg[63:2]), 2'h0})
    else $error("supervisor return target wrong");

  a_link_flag: assert property (
    @(posedge i_clk) disable iff (i_reset)
    finish
    |=> o_link_undefined == $past(link_reg_q))
    else $error("link flag not reported");

  a_dw_bits: assert property (
    @(posedge i_clk) disable iff (i_reset)
    finish && op_reg == iru_pkg::IRU_OP_RET_DW
    |=> (o_machine_state_reg & iru_pkg::MASK_DW_RET) ==
        ($past(i_save_restore_state_reg) & iru_pkg::MASK_DW_RET))
    else $error("doubleword state bits wrong");

  a_sf_target: assert property (
    @(posedge i_clk) disable iff (i_reset)
    finish && op_reg == iru_pkg::IRU_OP_RET_DW && new_msr[iru_pkg::POS_SF]
    |=> o_redirect_addr == {$past(i_save_restore_addr_reg[63:2]), 2'h0})
    else $error("64-bit target wrong");

  a_hi_clear: assert property (
    @(posedge i_clk) disable iff (i_reset)
    finish && op_reg == iru_pkg::IRU_OP_RET_DW && !new_msr[iru_pkg::POS_SF]
    |=> o_redirect_addr[63:32] == 32'h0)
    else $error("high address not cleared");

  a_lo_word: assert property (
    @(posedge i_clk) disable iff (i_reset)
    finish && op_reg == iru_pkg::IRU_OP_RET_DW && !new_msr[iru_pkg::POS_SF]
    |=> o_redirect_addr[31:0] == {$past(i_save_restore_addr_reg[31:2]), 2'h0})
    else $error("low address word wrong");

  a_redeliver: assert property (
    @(posedge i_clk) disable iff (i_reset)
    redeliv
    |=> o_exc_raise && o_save_addr_we && !o_redirect)
    else $error("pending exception not raised");

  a_event_set: assert property (
    @(posedge i_clk) disable iff (i_reset)
    finish
    |=> status_reg[iru_pkg::ST_RETURN])
    else $error("return event not latched");

  c_word_ret: cover property (@(posedge i_clk) disable iff (i_reset)
    finish && op_reg == iru_pkg::IRU_OP_RET);

  c_svc_ret: cover property (@(posedge i_clk) disable iff (i_reset)
    finish && op_reg == iru_pkg::IRU_OP_SVC);

  c_redeliv: cover property (@(posedge i_clk) disable iff (i_reset)
    redeliv);

  c_priv: cover property (@(posedge i_clk) disable iff (i_reset)
    want_priv);

  c_ill: cover property (@(posedge i_clk) disable iff (i_reset)
    want_ill);

endmodule

`default_nettype wire

/* dv/iru_far_model.sv */
/*
  Far-side model: older instructions drain for a set number of cycles.
  Assumes the unit's busy level and a delay chosen by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module iru_far_model (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_busy,
  input  wire logic [3:0] i_dly,
  output logic            o_older_done
);
  logic [3:0] cnt_reg;
  // older work completes dly cycles into the drain
  assign o_older_done = i_busy && (cnt_reg >= i_dly);
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) cnt_reg <= 4'h0;
    else if (!i_busy) cnt_reg <= 4'h0;
    else if (cnt_reg != 4'hF) cnt_reg <= cnt_reg + 4'h1;
  end
endmodule

`default_nettype wire

/* dv/testbench.sv */
/*
  Testbench: return instructions and Avalon-MM register access.
  Assumes iru_pkg, iru_top and iru_far_model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g,e) chk(((g) === (e)), 64'(g), 64'(e));

module testbench;
  logic        i_clk, i_reset, i_issue, i_exc_pending, i_avs_read;
  logic        i_avs_write, i_older_done, o_avs_waitrequest, o_busy;
  logic        o_redirect, o_exc_raise, o_priv_exc, o_illegal_exc;
  logic        o_save_addr_we, o_link_undefined, o_irq, ill2;
  logic        s_red, s_exr, s_priv, s_ill, s_lu, s_ill2;
  logic [3:0]  dly;
  logic [5:0]  i_avs_address;
  logic [31:0] i_instr, i_avs_writedata, o_avs_readdata, rd_v;
  logic [63:0] i_save_restore_addr_reg, i_save_restore_state_reg;
  logic [63:0] i_count_reg, i_link_reg, o_redirect_addr, o_save_addr_value;
  logic [63:0] o_machine_state_reg, msr_e, mw, md;
  int          err_count, cmp_count, n_last;

  iru_top i_iru_top (.i_clk, .i_reset, .i_issue, .i_instr, .i_older_done,
    .i_save_restore_addr_reg, .i_save_restore_state_reg, .i_count_reg,
    .i_link_reg, .i_exc_pending, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_busy,
    .o_redirect, .o_redirect_addr, .o_machine_state_reg, .o_exc_raise,
    .o_priv_exc, .o_illegal_exc, .o_save_addr_we, .o_save_addr_value,
    .o_link_undefined, .o_irq);
  iru_top #(.IS_64BIT(1'b0)) i_iru_top_32 (.i_clk, .i_reset, .i_issue,
    .i_instr, .i_older_done, .i_save_restore_addr_reg,
    .i_save_restore_state_reg, .i_count_reg, .i_link_reg, .i_exc_pending,
    .i_avs_address, .i_avs_read(1'b0), .i_avs_write(1'b0), .i_avs_writedata,
    .o_avs_readdata(), .o_avs_waitrequest(), .o_busy(), .o_redirect(),
    .o_redirect_addr(), .o_machine_state_reg(), .o_exc_raise(),
    .o_priv_exc(), .o_illegal_exc(ill2), .o_save_addr_we(),
    .o_save_addr_value(), .o_link_undefined(), .o_irq());
  iru_far_model i_iru_far_model (.i_clk, .i_reset, .i_busy(o_busy),
    .i_dly(dly), .o_older_done(i_older_done));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    #20000;
    err_count++;
    stop_test();
  end
  ////////////////////////////////////////
  task automatic chk(input bit ok, input logic [63:0] g, e);
    cmp_count++;
    if (!ok) begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input bit w, input logic [5:0] a, input [31:0] d);
    @(posedge i_clk);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do begin
      @(posedge i_clk);
    end while (o_avs_waitrequest !== 1'b0);
    rd_v = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic ret(input logic [9:0] xo, input bit lk);
    int n;
    @(posedge i_clk);
    i_issue <= 1'b1;
    i_instr <= {iru_pkg::OPC_PRIMARY, 15'h0, xo, lk};
    @(posedge i_clk);
    i_issue <= 1'b0;
    {s_red, s_exr, s_priv, s_ill, s_lu, s_ill2} = '0;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      s_red |= o_redirect;
      s_exr |= o_exc_raise & o_save_addr_we;
      s_priv |= o_priv_exc;
      s_ill |= o_illegal_exc;
      s_lu |= o_link_undefined;
      s_ill2 |= ill2;
    end while (o_busy !== 1'b0 || n < 2);
    n_last = n;
  endtask
  task automatic stop_test();
    $display("err_count=%0d cmp_count=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    {i_reset, i_issue, i_exc_pending, i_avs_read, i_avs_write} = 5'b10000;
    {i_instr, i_avs_writedata, i_avs_address, dly} = '0;
    {i_save_restore_addr_reg, i_save_restore_state_reg} = '0;
    {i_count_reg, i_link_reg} = '0;
    {err_count, cmp_count} = '0;
    mw = iru_pkg::MASK_WORD_RET;
    md = iru_pkg::MASK_DW_RET;
    msr_e = iru_pkg::RST_STATE;
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    bus(0, iru_pkg::OFF_CTRL, 0);
    `CHK(rd_v, iru_pkg::RST_CTRL)
    bus(0, iru_pkg::OFF_STATE_HI, 0);
    `CHK(rd_v, msr_e[63:32])
    bus(0, 6'h3C, 0);
    `CHK(rd_v, iru_pkg::UNMAPPED_RD)
    bus(1, iru_pkg::OFF_MASK, 32'hF);
    i_save_restore_state_reg <= '1;
    i_save_restore_addr_reg <= 64'h1234_5678_9ABC_DEF3;
    ret(iru_pkg::XO_INT_RET, 1);
    msr_e = (msr_e & ~mw) | ('1 & mw);
    `CHK(o_machine_state_reg, msr_e)
    `CHK(s_red, 1'b1)
    `CHK(o_redirect_addr, 64'h1234_5678_9ABC_DEF0)
    `CHK(s_lu, 1'b1)
    `CHK(o_irq, 1'b1)
    dly <= 4'h5;
    i_count_reg <= 64'h0000_A5A5_0000_0000;
    i_link_reg <= 64'hFEDC_BA98_7654_3217;
    ret(iru_pkg::XO_SVC_RET, 1);
    msr_e = (msr_e & ~mw) | (i_count_reg & mw);
    `CHK(o_machine_state_reg, msr_e)
    `CHK(o_redirect_addr, 64'hFEDC_BA98_7654_3214)
    `CHK(s_lu, 1'b1)
    `CHK(n_last > 5, 1'b1)
    dly <= 4'h0;
    i_exc_pending <= 1'b1;
    i_save_restore_state_reg <= 64'h8000_0000_0000_00A3;
    i_save_restore_addr_reg <= 64'hCAFE_0000_1234_567F;
    ret(iru_pkg::XO_INT_RET_DW, 0);
    msr_e = (msr_e & ~md) | (i_save_restore_state_reg & md);
    `CHK(o_machine_state_reg, msr_e)
    `CHK({s_red, s_exr}, 2'b10)
    `CHK(o_redirect_addr, 64'hCAFE_0000_1234_567C)
    `CHK({s_ill, s_ill2}, 2'b01)
    `CHK(s_lu, 1'b0)
    i_save_restore_state_reg <= 64'h0000_0000_0000_8000;
    ret(iru_pkg::XO_INT_RET_DW, 0);
    msr_e = (msr_e & ~md) | (i_save_restore_state_reg & md);
    `CHK(o_machine_state_reg, msr_e)
    `CHK({s_red, s_exr}, 2'b01)
    `CHK(o_save_addr_value, 64'h0000_0000_1234_567C)
    bus(0, iru_pkg::OFF_STATUS, 0);
    `CHK(rd_v, 32'h9)
    bus(1, iru_pkg::OFF_STATUS, 32'hF);
    i_exc_pending <= 1'b0;
    i_save_restore_state_reg <= 64'h0000_0000_0000_4000;
    ret(iru_pkg::XO_INT_RET_DW, 0);
    msr_e = (msr_e & ~md) | (i_save_restore_state_reg & md);
    `CHK(o_redirect_addr, 64'h0000_0000_1234_567C)
    i_save_restore_state_reg <= '1;
    ret(iru_pkg::XO_INT_RET, 0);
    `CHK({s_priv, s_red}, 2'b10)
    `CHK(o_machine_state_reg, msr_e)
    bus(1, iru_pkg::OFF_MASK, 32'h0);
    bus(0, iru_pkg::OFF_STATUS, 0);
    `CHK(rd_v, 32'h3)
    `CHK(o_irq, 1'b0)
    bus(1, iru_pkg::OFF_MASK, 32'hF);
    @(posedge i_clk);
    `CHK(o_irq, 1'b1)
    bus(1, iru_pkg::OFF_STATUS, 32'hF);
    bus(0, iru_pkg::OFF_STATUS, 0);
    `CHK(rd_v, 32'h0)
    `CHK(o_irq, 1'b0)
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    `CHK(o_machine_state_reg, iru_pkg::RST_STATE)
    stop_test();
  end
endmodule

`default_nettype wire
